// >>> rtl/kbd_scan_pkg.sv
// constants, register map and types of the keyboard matrix scanner
package kbd_scan_pkg;

    // clock and scan timing
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int SCAN_FREQ_KHZ = 15;
    localparam int SCAN_DIV_W = 10;
    localparam int KEY_CNT_W = 6;

    // avalon slave geometry, byte addressed, one word per register
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int IDX_W = 16;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_KEY_SCAN_CODE = 16'hd209;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 16'hd210;
    localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 16'hd211;
    localparam logic [IDX_W-1:0] IDX_KBD_STATUS = 16'hd212;
    localparam logic [IDX_W-1:0] IDX_KBD_CONTROL = 16'hd213;
    localparam logic [IDX_W-1:0] IDX_STATUS_RESET = 16'hd214;

    // field positions
    localparam int KC_SHIFT_BIT = 6;
    localparam int KC_CTRL_BIT = 7;
    localparam int INT_KEY_BIT = 6;
    localparam int ST_OVERRUN_N_BIT = 6;
    localparam int ST_SHIFT_N_BIT = 3;
    localparam int ST_KEY_UP_BIT = 2;
    localparam int CTL_DEBOUNCE_BIT = 0;
    localparam int CTL_SCAN_EN_BIT = 1;

    // modifier sampling slots of the key counter
    localparam logic [KEY_CNT_W-1:0] CTRL_SLOT = 6'h00;
    localparam logic [KEY_CNT_W-1:0] SHIFT_SLOT = 6'h10;

    // reset values
    localparam logic [7:0] KEY_CODE_RST = 8'h00;
    localparam logic [7:0] INT_STATUS_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    localparam logic [7:0] KBD_STATUS_RST = 8'h4c;
    localparam logic [7:0] KBD_CONTROL_RST = 8'h00;

    // scanner states
    typedef enum logic [1:0] {
        ST_KEY_UP = 2'b00,
        ST_DEB_DOWN = 2'b01,
        ST_DEB_UP = 2'b10,
        ST_KEY_DOWN = 2'b11
    } scan_state_t;

endpackage

// >>> rtl/keyboard_matrix_scanner.sv
// keyboard matrix scanner with avalon-mm register slave and key interrupt
// Summary of operation
// - confirmed press loads the six-bit scan code into key code bits 0-5
// - confirmed press sets interrupt status bit 6 when its enable bit is set
// - shift and control captured into key code bits 6 and 7 with each code
// - status bit 3 follows shift whenever it is sampled, without other keys
// - key release leaves key code and interrupt status untouched
// - press confirmed while interrupt bit 6 pending clears status bit 6
// - reading the key code has no side effect on interrupt or overrun
// - any write to the status reset strobe clears the overrun flag
// - one of 64 keys examined per 15 kHz scan tick, 4.26 ms per pass
// - six-bit counter, six-bit compare register and four-state machine
// - key up with scanned key down latches counter, enters debounce down
// - debounce down returns to key up on match-and-up or mismatch-and-down
// - debounce down match-and-down: interrupt, clear bit 2, load code, down
// - confirmed down on match-and-up moves to debounce up
// - debounce up on match-and-up sets status bit 2, returns to key up
// - debounce off makes every counter-versus-compare test a match
// - control sampled at slot 00, shift at slot 10, held in latches
// - scan disabled forces key up state and holds counter at zero
`timescale 1ns/1ps
`default_nettype none

module keyboard_matrix_scanner #(
    parameter int CLK_FREQ_KHZ = kbd_scan_pkg::CLK_FREQ_KHZ,
    parameter int SCAN_FREQ_KHZ = kbd_scan_pkg::SCAN_FREQ_KHZ
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [kbd_scan_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [kbd_scan_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [kbd_scan_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic [kbd_scan_pkg::KEY_CNT_W-1:0] key_select,
    input wire logic key_sense_n,
    input wire logic modifier_sense_n
);
    import kbd_scan_pkg::*;

    // clock cycles per scan tick, rounded down so a pass never runs slow
    localparam int SCAN_DIV = CLK_FREQ_KHZ / SCAN_FREQ_KHZ;
    localparam logic [SCAN_DIV_W-1:0] DIV_LAST = SCAN_DIV_W'(SCAN_DIV - 1);

    // the divider must fit and leave the synchronisers time to settle
    if (SCAN_DIV < 8 || SCAN_DIV > (2 ** SCAN_DIV_W)) begin : g_bad_div
        $error("scan divider out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0] key_sync;
        logic [1:0] mod_sync;
        logic [SCAN_DIV_W-1:0] div;
        logic tick;
        logic [KEY_CNT_W-1:0] cnt;
        logic [KEY_CNT_W-1:0] cmp;
        scan_state_t fsm;
        logic ctrl_latch;
        logic shift_latch;
        logic [7:0] key_code;
        logic [7:0] int_status;
        logic [7:0] int_enable;
        logic [7:0] kbd_status;
        logic [7:0] kbd_control;
        logic irq;
        logic waitreq;
        logic [7:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic key_down;
    logic mod_down;
    logic scan_on;
    logic step;
    logic match;
    logic confirm;
    logic bus_req;
    logic bus_done;
    logic [IDX_W-1:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // decode of scan and bus conditions

    // only the second synchroniser stage is looked at
    assign key_down = ~s_reg.key_sync[1];
    assign mod_down = ~s_reg.mod_sync[1];
    assign scan_on = s_reg.kbd_control[CTL_SCAN_EN_BIT];
    assign step = s_reg.tick & scan_on;
    // without debounce the compare always passes
    assign match = ~s_reg.kbd_control[CTL_DEBOUNCE_BIT] | (s_reg.cnt == s_reg.cmp);
    assign confirm = step & (s_reg.fsm == ST_DEB_DOWN) & match & key_down;
    assign bus_req = avs_read | avs_write;
    // a transfer completes on the edge where waitrequest is seen low
    assign bus_done = bus_req & ~s_reg.waitreq;
    assign idx = avs_address[ADDR_W-1:2];

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;

        // two-flop synchronisers on the matrix return lines
        s_next.key_sync = {s_reg.key_sync[0], key_sense_n};
        s_next.mod_sync = {s_reg.mod_sync[0], modifier_sense_n};

        // scan tick divider
        if (s_reg.div == DIV_LAST) begin
            s_next.div = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + SCAN_DIV_W'(1);
            s_next.tick = 1'b0;
        end

        // bus writes first, so hardware events below win over clears
        if (avs_write && bus_done) begin
            if (idx == IDX_STATUS_RESET) begin
                s_next.kbd_status[ST_OVERRUN_N_BIT] = 1'b1;
            end
            if (avs_byteenable[0]) begin
                unique case (idx)
                    IDX_INT_ENABLE: begin
                        s_next.int_enable = avs_writedata[7:0];
                        // dropping an enable also drops its pending bit
                        s_next.int_status = s_reg.int_status & avs_writedata[7:0];
                    end
                    IDX_INT_STATUS: begin
                        s_next.int_status = s_reg.int_status & ~avs_writedata[7:0];
                    end
                    IDX_KBD_CONTROL: begin
                        s_next.kbd_control = avs_writedata[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // modifier sampling runs beside the normal key check
        if (step && s_reg.cnt == CTRL_SLOT) begin
            s_next.ctrl_latch = mod_down;
        end
        if (step && s_reg.cnt == SHIFT_SLOT) begin
            s_next.shift_latch = mod_down;
            s_next.kbd_status[ST_SHIFT_N_BIT] = ~mod_down;
        end

        // key state machine, one key per tick
        if (!scan_on) begin
            // held idle; code and pending interrupt stay as they are
            s_next.fsm = ST_KEY_UP;
            s_next.cnt = '0;
            s_next.kbd_status[ST_KEY_UP_BIT] = 1'b1;
        end else if (s_reg.tick) begin
            unique case (s_reg.fsm)
                ST_KEY_UP: begin
                    if (key_down) begin
                        s_next.cmp = s_reg.cnt;
                        s_next.fsm = ST_DEB_DOWN;
                    end
                end
                ST_DEB_DOWN: begin
                    if (match && key_down) begin
                        s_next.fsm = ST_KEY_DOWN;
                        s_next.kbd_status[ST_KEY_UP_BIT] = 1'b0;
                        // modifiers travel with the code, not on their own
                        s_next.key_code = {s_reg.ctrl_latch, s_reg.shift_latch,
                            s_reg.cnt};
                        if (s_reg.int_enable[INT_KEY_BIT]) begin
                            s_next.int_status[INT_KEY_BIT] = 1'b1;
                        end
                        if (s_reg.int_status[INT_KEY_BIT]) begin
                            s_next.kbd_status[ST_OVERRUN_N_BIT] = 1'b0;
                        end
                    end else if ((match && !key_down) || (!match && key_down)) begin
                        s_next.fsm = ST_KEY_UP;
                    end
                end
                ST_KEY_DOWN: begin
                    // release touches neither code nor interrupt
                    if (match && !key_down) begin
                        s_next.fsm = ST_DEB_UP;
                    end
                end
                ST_DEB_UP: begin
                    if (match && !key_down) begin
                        s_next.fsm = ST_KEY_UP;
                        s_next.kbd_status[ST_KEY_UP_BIT] = 1'b1;
                    end
                end
            endcase
            // other conditions keep the state; counter wraps freely
            s_next.cnt = s_reg.cnt + KEY_CNT_W'(1);
        end

        // read data captured in the wait cycle, no read side effects
        if (bus_req && s_reg.waitreq) begin
            s_next.waitreq = 1'b0;
            unique case (idx)
                IDX_KEY_SCAN_CODE: s_next.rdata = s_reg.key_code;
                IDX_INT_STATUS: s_next.rdata = s_reg.int_status;
                IDX_INT_ENABLE: s_next.rdata = s_reg.int_enable;
                IDX_KBD_STATUS: s_next.rdata = s_reg.kbd_status;
                IDX_KBD_CONTROL: s_next.rdata = s_reg.kbd_control;
                default: s_next.rdata = 8'h00;
            endcase
        end else begin
            s_next.waitreq = 1'b1;
        end

        // level interrupt from the registered next values
        s_next.irq = |(s_next.int_status & s_next.int_enable);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // every field takes a constant under reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg.key_sync <= 2'h3;
            s_reg.mod_sync <= 2'h3;
            s_reg.div <= '0;
            s_reg.tick <= 1'b0;
            s_reg.cnt <= '0;
            s_reg.cmp <= '0;
            s_reg.fsm <= ST_KEY_UP;
            s_reg.ctrl_latch <= 1'b0;
            s_reg.shift_latch <= 1'b0;
            s_reg.key_code <= KEY_CODE_RST;
            s_reg.int_status <= INT_STATUS_RST;
            s_reg.int_enable <= INT_ENABLE_RST;
            s_reg.kbd_status <= KBD_STATUS_RST;
            s_reg.kbd_control <= KBD_CONTROL_RST;
            s_reg.irq <= 1'b0;
            s_reg.waitreq <= 1'b1;
            s_reg.rdata <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign avs_readdata = {24'h000000, s_reg.rdata};
    assign avs_waitrequest = s_reg.waitreq;
    assign irq = s_reg.irq;
    assign key_select = s_reg.cnt;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic strobe_wr;
    assign strobe_wr = avs_write & bus_done & (idx == IDX_STATUS_RESET);

    sequence press_seen;
        step && s_reg.fsm == ST_KEY_UP && key_down;
    endsequence

    sequence release_seen;
        step && s_reg.fsm == ST_KEY_DOWN && match && !key_down;
    endsequence

    sequence settle_up;
        step && s_reg.fsm == ST_DEB_UP && match && !key_down;
    endsequence

    code_load_a: assert property (confirm |=> s_reg.key_code[5:0] == $past(s_reg.cnt))
        else $error("scan code not loaded on confirmed press");

    key_irq_a: assert property (confirm && s_reg.int_enable[INT_KEY_BIT]
        |=> s_reg.int_status[INT_KEY_BIT] && irq)
        else $error("key interrupt not raised");

    mods_capture_a: assert property (confirm |=>
        s_reg.key_code[KC_SHIFT_BIT] == $past(s_reg.shift_latch)
        && s_reg.key_code[KC_CTRL_BIT] == $past(s_reg.ctrl_latch))
        else $error("modifier bits not captured with code");

    code_hold_a: assert property (!confirm |=> $stable(s_reg.key_code))
        else $error("key code changed without a press");

    shift_track_a: assert property (step && s_reg.cnt == SHIFT_SLOT
        |=> s_reg.kbd_status[ST_SHIFT_N_BIT] == !$past(mod_down))
        else $error("shift status not updated");

    release_quiet_a: assert property (release_seen |=> s_reg.fsm == ST_DEB_UP
        && $stable(s_reg.key_code) && ($past(avs_write) || $stable(s_reg.int_status)))
        else $error("release disturbed code or interrupt");

    overrun_a: assert property (confirm && s_reg.int_status[INT_KEY_BIT]
        |=> !s_reg.kbd_status[ST_OVERRUN_N_BIT])
        else $error("overrun not flagged");

    read_clean_a: assert property (avs_read && bus_done && !confirm && !avs_write
        |=> $stable(s_reg.int_status) && $stable(s_reg.kbd_status[ST_OVERRUN_N_BIT]))
        else $error("read changed interrupt or overrun");

    strobe_clear_a: assert property (strobe_wr && !confirm
        |=> s_reg.kbd_status[ST_OVERRUN_N_BIT])
        else $error("overrun not cleared by strobe");

    scan_rate_a: assert property (s_reg.tick |=> (!s_reg.tick)[*6])
        else $error("scan ticks too close");

    count_step_a: assert property (step |=> s_reg.cnt == $past(s_reg.cnt) + 6'h01)
        else $error("key counter did not advance");

    press_latch_a: assert property (press_seen |=> s_reg.fsm == ST_DEB_DOWN
        && s_reg.cmp == $past(s_reg.cnt))
        else $error("press not latched into compare");

    deb_reject_a: assert property (step && s_reg.fsm == ST_DEB_DOWN
        && (match ^ key_down) |=> s_reg.fsm == ST_KEY_UP)
        else $error("debounce down did not reject");

    confirm_a: assert property (confirm |=> s_reg.fsm == ST_KEY_DOWN
        && !s_reg.kbd_status[ST_KEY_UP_BIT])
        else $error("press not confirmed");

    settle_a: assert property (settle_up |=> s_reg.fsm == ST_KEY_UP
        && s_reg.kbd_status[ST_KEY_UP_BIT])
        else $error("release not settled");

    no_debounce_a: assert property (step && !s_reg.kbd_control[CTL_DEBOUNCE_BIT]
        && s_reg.fsm == ST_DEB_DOWN && key_down |=> s_reg.fsm == ST_KEY_DOWN)
        else $error("compare not forced to match");

    ctrl_sample_a: assert property (step && s_reg.cnt == CTRL_SLOT
        |=> s_reg.ctrl_latch == $past(mod_down))
        else $error("control not sampled");

    scan_off_a: assert property (!scan_on |=> s_reg.fsm == ST_KEY_UP
        && s_reg.cnt == 6'h00 && $stable(s_reg.key_code))
        else $error("disabled scan not held idle");

    hold_state_a: assert property (step && s_reg.fsm == ST_KEY_DOWN
        && !(match && !key_down) |=> s_reg.fsm == ST_KEY_DOWN)
        else $error("state left without cause");

    bus_answer_a: assert property (bus_req && s_reg.waitreq |=> !avs_waitrequest)
        else $error("bus not answered in one wait cycle");

endmodule

`default_nettype wire

// >>> tb/key_matrix_model.sv
// passive key switch matrix on the far side of the scanner
`timescale 1ns/1ps
`default_nettype none

module key_matrix_model (
    input wire logic [kbd_scan_pkg::KEY_CNT_W-1:0] key_select,
    input wire logic [63:0] keys_down,
    input wire logic ctrl_down,
    input wire logic shift_down,
    output logic key_sense_n,
    output logic modifier_sense_n
);
    import kbd_scan_pkg::*;

    // a closed switch pulls the return line low; no diodes, no memory
    assign key_sense_n = !keys_down[key_select];
    // modifiers share the return line with their own slots only
    assign modifier_sense_n = !((key_select == CTRL_SLOT && ctrl_down) ||
        (key_select == SHIFT_SLOT && shift_down));
endmodule

`default_nettype wire

// >>> tb/keyboard_matrix_scanner_tb.sv
// self-checking bench for the keyboard matrix scanner
`timescale 1ns/1ps
`default_nettype none

module keyboard_matrix_scanner_tb;
    import kbd_scan_pkg::*;

    localparam int TICK = 16; // clk per scan tick with the shortened divider
    localparam int PASS = 64 * TICK;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic key_sense_n, modifier_sense_n, ctrl_down, shift_down;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [KEY_CNT_W-1:0] key_select;
    logic [63:0] keys_down;
    int mismatches, total_checks;

    keyboard_matrix_scanner #(.CLK_FREQ_KHZ(16), .SCAN_FREQ_KHZ(1)) dut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .key_select(key_select), .key_sense_n(key_sense_n),
        .modifier_sense_n(modifier_sense_n));

    key_matrix_model matrix (.key_select(key_select), .keys_down(keys_down),
        .ctrl_down(ctrl_down), .shift_down(shift_down), .key_sense_n(key_sense_n),
        .modifier_sense_n(modifier_sense_n));

    ////////////////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task fail_out;
        mismatches++;
        close_out;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon transfer; held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_out;
        // data and completion both taken at the edge that sees waitrequest low
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task rchk(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        check(d, {24'h0, exp});
    endtask

    // repeated reads until a field settles; bound covers several passes
    task poll(input logic [15:0] idx, input logic [7:0] mask, input logic [7:0] val);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            bus(1'b0, idx, 8'h00, d);
            n++;
        end while ((d[7:0] & mask) !== val && n < 2000);
        if (n >= 2000) fail_out;
    endtask

    task set_keys(input logic [63:0] k, input logic c, input logic s);
        @(posedge clk);
        keys_down <= k;
        ctrl_down <= c;
        shift_down <= s;
    endtask

    task sel_step(output int n);
        logic [KEY_CNT_W-1:0] k;
        k = key_select;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (key_select === k && n < 4 * TICK);
        if (n >= 4 * TICK) fail_out;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task s_reset;
        rchk(IDX_KEY_SCAN_CODE, KEY_CODE_RST);
        rchk(IDX_INT_STATUS, INT_STATUS_RST);
        rchk(IDX_INT_ENABLE, INT_ENABLE_RST);
        rchk(IDX_KBD_STATUS, KBD_STATUS_RST);
        rchk(IDX_KBD_CONTROL, KBD_CONTROL_RST);
        rchk(16'h0000, 8'h00); // unmapped place reads zero
        wr(IDX_KEY_SCAN_CODE, 8'hff);
        rchk(IDX_KEY_SCAN_CODE, 8'h00);
    endtask

    task s_tick;
        int n, i;
        wr(IDX_INT_ENABLE, 8'h40);
        wr(IDX_KBD_CONTROL, 8'h03);
        sel_step(n);
        sel_step(n);
        check(n, TICK);
        i = 0;
        while (key_select !== 6'h3f && i < 70) begin
            sel_step(n);
            i++;
        end
        if (i >= 70) fail_out;
        sel_step(n);
        check(key_select, 32'h0);
    endtask

    task s_press;
        set_keys(64'h1 << 6'h25, 1'b0, 1'b1);
        poll(IDX_KBD_STATUS, 8'h04, 8'h00);
        rchk(IDX_KEY_SCAN_CODE, 8'h65);
        rchk(IDX_KEY_SCAN_CODE, 8'h65);
        rchk(IDX_INT_STATUS, 8'h40);
        check(irq, 32'h1);
        rchk(IDX_KBD_STATUS, 8'h40);
    endtask

    // release of key and shift; code and pending interrupt must survive
    task s_release;
        set_keys(64'h0, 1'b0, 1'b0);
        poll(IDX_KBD_STATUS, 8'h04, 8'h04);
        rchk(IDX_KBD_STATUS, 8'h4c);
        rchk(IDX_KEY_SCAN_CODE, 8'h65);
        rchk(IDX_INT_STATUS, 8'h40);
    endtask

    task s_overrun;
        set_keys(64'h1 << 6'h0a, 1'b1, 1'b0);
        poll(IDX_KBD_STATUS, 8'h04, 8'h00);
        rchk(IDX_KEY_SCAN_CODE, 8'h8a);
        rchk(IDX_KBD_STATUS, 8'h08);
        wr(IDX_STATUS_RESET, 8'h00);
        rchk(IDX_KBD_STATUS, 8'h48);
        wr(IDX_INT_STATUS, 8'h40);
        rchk(IDX_INT_STATUS, 8'h00);
        check(irq, 32'h0);
        set_keys(64'h0, 1'b0, 1'b0);
        poll(IDX_KBD_STATUS, 8'h04, 8'h04);
    endtask

    // with debounce on two keys together never confirm; masked press updates code only
    task s_mask;
        set_keys(64'h3 << 6'h02, 1'b0, 1'b0);
        repeat (3 * PASS) @(posedge clk);
        rchk(IDX_KBD_STATUS, 8'h4c);
        wr(IDX_INT_ENABLE, 8'h00);
        set_keys(64'h1 << 6'h05, 1'b0, 1'b0);
        poll(IDX_KBD_STATUS, 8'h04, 8'h00);
        rchk(IDX_KEY_SCAN_CODE, 8'h05);
        rchk(IDX_INT_STATUS, 8'h00);
        check(irq, 32'h0);
    endtask

    task s_disable;
        int bad;
        bad = 0;
        wr(IDX_KBD_CONTROL, 8'h01);
        rchk(IDX_KBD_STATUS, 8'h4c);
        // shift pressed while idle must not reach the status bit
        set_keys(64'h1 << 6'h05, 1'b0, 1'b1);
        repeat (5 * TICK) begin
            @(negedge clk);
            if (key_select !== 6'h00) bad++;
        end
        check(bad, 32'h0);
        rchk(IDX_KBD_STATUS, 8'h4c);
        rchk(IDX_KEY_SCAN_CODE, 8'h05);
        set_keys(64'h0, 1'b0, 1'b0);
    endtask

    // with debounce off two neighbouring keys confirm the second one
    task s_nodebounce;
        wr(IDX_INT_ENABLE, 8'h40);
        wr(IDX_KBD_CONTROL, 8'h02);
        set_keys(64'h3 << 6'h30, 1'b0, 1'b0);
        poll(IDX_INT_STATUS, 8'h40, 8'h40);
        rchk(IDX_KEY_SCAN_CODE, 8'h31);
        check(irq, 32'h1);
        // dropping the enable drops the pending bit; repeats stay masked
        wr(IDX_INT_ENABLE, 8'h00);
        rchk(IDX_INT_STATUS, 8'h00);
        check(irq, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mismatches = 0;
        total_checks = 0;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        keys_down = 64'h0;
        ctrl_down = 1'b0;
        shift_down = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        s_reset;
        s_tick;
        s_press;
        s_release;
        s_overrun;
        s_mask;
        s_disable;
        s_nodebounce;
        close_out;
    end
endmodule

`default_nettype wire
